// file: cpu_exception_sequencer.sv
`timescale 1ns/10ps
`include "exc_seq_cfg.svh"

// Operation
// - odd or peripheral fetch is address error
// - single-chip mode: external space access errors
// - odd 16-bit data access errors, any master
// - unaligned 32-bit data access errors, any master
// - peripheral space data accesses never error
// - error taken once the instruction finishes
// - push status then faulting or branch address
// - fetch vector, jump without delay slot
// - nmi, break, eight pins, peripheral sources
// - levels 0..16, nmi 16 accepted at any mask
// - break level 15, still maskable
// - pin and peripheral levels 0 to 15
// - accept only when level exceeds mask
// - push, then mask gets level; nmi 15
// - trap pushes next address, uses immediate
// - undefined or pc change in slot
// - slot illegal pushes branch target address
// - undefined outside slot pushes own address
// - only 0xF000..0xFFFF undefined codes guaranteed
// - slot faults taken before the branch
// - interrupts held across delayed branch slot
// - interrupts held one instruction after ctrl ld/st
// - vector address is base plus four times number
// - each push predecrements stack by four
module cpu_exception_sequencer
	import exc_seq_pkg::*;
#(
	parameter int EXT_PINS = 8
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// mode
	input  wire logic                  single_chip_mode,
	// instruction fetch monitor
	input  wire logic                  fetch_valid,
	input  wire logic [31:0]           fetch_addr,
	// data access monitor
	input  wire logic                  data_valid,
	input  wire access_size_t          data_size,
	input  wire bus_master_t           data_master,
	input  wire logic [31:0]           data_addr,
	// retire boundary from the pipeline
	input  wire logic                  retire,
	input  wire logic [15:0]           retire_code,
	input  wire logic [31:0]           retire_addr,
	input  wire logic [31:0]           retire_next_addr,
	input  wire logic                  retire_undefined,
	input  wire logic                  retire_pc_change,
	input  wire logic                  retire_dly_branch,
	input  wire logic                  retire_in_slot,
	input  wire logic [31:0]           retire_branch_addr,
	input  wire logic [31:0]           retire_branch_target,
	input  wire logic                  retire_trap,
	input  wire logic [7:0]            retire_trap_vector,
	input  wire logic                  retire_ctrl_ldst,
	// cpu state
	input  wire logic [31:0]           status_word,
	input  wire logic [31:0]           stack_pointer,
	input  wire logic [31:0]           vector_base,
	// interrupt requests
	input  wire logic                  nmi_req,
	input  wire logic                  break_req,
	input  wire logic [EXT_PINS-1:0]   external_request_pins,
	input  wire logic [EXT_PINS*4-1:0] priority_level_regs,
	input  wire logic                  periph_req,
	input  wire logic [3:0]            periph_level,
	input  wire logic [7:0]            periph_vector,
	// address error flags
	output logic                       fetch_fault,
	output logic                       data_fault,
	// sequencer status and interrupt acknowledge
	output logic                       seq_busy,
	output logic                       int_ack,
	output logic [7:0]                 int_ack_vector,
	// stack write port
	output logic                       stack_wr,
	output logic [31:0]                stack_addr,
	output logic [31:0]                stack_data,
	input  wire logic                  stack_ack,
	// vector read port
	output logic                       vec_rd,
	output logic [31:0]                vec_addr,
	input  wire logic                  vec_ack,
	input  wire logic [31:0]           vec_data,
	// results to the cpu
	output logic                       jump_valid,
	output logic [31:0]                jump_addr,
	output logic                       sp_write,
	output logic [31:0]                sp_value,
	output logic                       mask_write,
	output logic [3:0]                 interrupt_mask_bits
);

	seq_state_t  state;
	seq_state_t  next_state;
	logic        cpu_err_pend;
	logic        dma_err_pend;
	logic [31:0] saved_sr;
	logic [31:0] saved_pc;
	logic [31:0] sp_work;
	logic [7:0]  vec_num;
	logic        is_int;
	logic [3:0]  int_mask_new;

	// address classification
	wire in_periph_f = fetch_addr >= `PERIPH_LO;
	wire in_ext_f    = fetch_addr >= `EXT_LO && fetch_addr <= `EXT_HI;
	wire in_periph_d = data_addr >= `PERIPH_LO;
	wire in_ext_d    = data_addr >= `EXT_LO && data_addr <= `EXT_HI;
	wire next_fetch_fault = fetch_valid && (fetch_addr[0] || in_periph_f
		|| (single_chip_mode && in_ext_f));
	wire word_odd  = data_size == SIZE_WORD && data_addr[0];
	wire long_mis  = data_size == SIZE_LONG && data_addr[1:0] != 2'b00;
	wire next_data_fault = data_valid && ((!in_periph_d && (word_odd || long_mis))
		|| (single_chip_mode && in_ext_d));
	// faults raised by the sequencer's own stacking are ignored to avoid looping
	wire idle      = state == ST_IDLE;
	wire cpu_fault = idle && (next_fetch_fault
		|| (next_data_fault && data_master == MASTER_CPU));
	wire dma_fault = idle && next_data_fault && data_master != MASTER_CPU;

	// interrupt ranking: chain of maxima over pins, peripheral and break
	logic [3:0] cand_lvl [EXT_PINS+1];
	logic [7:0] cand_vec [EXT_PINS+1];
	logic       cand_any [EXT_PINS+1];
	assign cand_lvl[0] = `LVL_BREAK;
	assign cand_vec[0] = `VEC_BREAK;
	assign cand_any[0] = break_req;
	genvar g;
	generate
		for (g = 0; g < EXT_PINS; g++) begin : g_rank
			wire [3:0] lvl  = priority_level_regs[g*4 +: 4];
			wire       wins = external_request_pins[g] && (!cand_any[g] || lvl > cand_lvl[g]);
			assign cand_lvl[g+1] = wins ? lvl : cand_lvl[g];
			assign cand_vec[g+1] = wins ? (`VEC_EXT_BASE + 8'(g)) : cand_vec[g];
			assign cand_any[g+1] = cand_any[g] || external_request_pins[g];
		end
	endgenerate
	wire        p_wins   = periph_req && (!cand_any[EXT_PINS] || periph_level > cand_lvl[EXT_PINS]);
	wire [3:0]  best_lvl = p_wins ? periph_level : cand_lvl[EXT_PINS];
	wire [7:0]  best_vec = p_wins ? periph_vector : cand_vec[EXT_PINS];
	wire        best_any = cand_any[EXT_PINS] || periph_req;
	wire [3:0]  cur_mask = status_word[`SR_MASK_MSB:`SR_MASK_LSB];
	wire        mask_ok  = best_any && best_lvl > cur_mask;
	// boundary after a delayed branch or a control-register move blocks interrupts;
	// requests are levels, so a held one is simply seen again next boundary
	wire        int_block = retire_dly_branch || retire_ctrl_ldst;
	wire        take_int  = retire && idle && !int_block && (nmi_req || mask_ok);

	// instruction exceptions
	wire undef_code = retire_undefined || retire_code[15:12] == `UNDEF_TOP_NIBBLE;
	wire slot_ill   = retire_in_slot && (undef_code || retire_pc_change);
	wire gen_ill    = !retire_in_slot && undef_code;
	wire take_aerr  = retire && idle && (cpu_err_pend || dma_err_pend || cpu_fault || dma_fault);
	wire take_ill   = retire && idle && (slot_ill || gen_ill);
	wire take_trap  = retire && idle && retire_trap;
	wire take_any   = take_aerr || take_ill || take_trap || take_int;
	wire aerr_cpu   = cpu_err_pend || cpu_fault;

	// cause selection: address error, illegal, trap, then interrupt
	wire [7:0] sel_vec =
		take_aerr ? (aerr_cpu ? `VEC_CPU_ADDR_ERR : `VEC_DMA_ADDR_ERR) :
		take_ill  ? (slot_ill ? `VEC_SLOT_ILLEGAL : `VEC_GEN_ILLEGAL) :
		take_trap ? retire_trap_vector :
		nmi_req   ? `VEC_NMI : best_vec;
	wire [31:0] sel_pc =
		take_aerr ? (retire_in_slot ? retire_branch_addr : retire_addr) :
		take_ill  ? (slot_ill ? retire_branch_target : retire_addr) :
		retire_next_addr;
	wire        sel_int  = !take_aerr && !take_ill && !take_trap;
	wire [3:0]  sel_mask = nmi_req ? `MASK_AFTER_NMI : best_lvl;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:    if (take_any) next_state = ST_PUSH_SR;
			ST_PUSH_SR: if (stack_ack) next_state = ST_PUSH_PC;
			ST_PUSH_PC: if (stack_ack) next_state = ST_VECTOR;
			ST_VECTOR:  if (vec_ack) next_state = ST_JUMP;
			ST_JUMP:    next_state = ST_IDLE;
			default:    next_state = ST_IDLE;
		endcase
	end

	assign seq_busy = !idle;
	assign stack_wr = state == ST_PUSH_SR || state == ST_PUSH_PC;
	assign vec_rd   = state == ST_VECTOR;
	assign stack_addr = sp_work - `STACK_STEP;
	assign stack_data = state == ST_PUSH_SR ? saved_sr : saved_pc;
	assign vec_addr   = vector_base + {22'h0, vec_num, 2'b00};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// sticky error flags: a fault stays until its own master's error is taken,
	// so a dma fault landing on a cpu error boundary is not lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cpu_err_pend <= 1'b0;
			dma_err_pend <= 1'b0;
			fetch_fault  <= 1'b0;
			data_fault   <= 1'b0;
		end else begin
			fetch_fault  <= next_fetch_fault;
			data_fault   <= next_data_fault;
			cpu_err_pend <= (cpu_err_pend || cpu_fault) && !(take_aerr && aerr_cpu);
			dma_err_pend <= (dma_err_pend || dma_fault) && !(take_aerr && !aerr_cpu);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			saved_sr     <= 32'h0000_0000;
			saved_pc     <= 32'h0000_0000;
			vec_num      <= 8'h00;
			is_int       <= 1'b0;
			int_mask_new <= 4'h0;
		end else if (idle && take_any) begin
			saved_sr     <= status_word;
			saved_pc     <= sel_pc;
			vec_num      <= sel_vec;
			is_int       <= sel_int;
			int_mask_new <= sel_mask;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sp_work <= 32'h0000_0000;
		end else if (idle && take_any) begin
			sp_work <= stack_pointer;
		end else if (stack_wr && stack_ack) begin
			sp_work <= sp_work - `STACK_STEP;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			jump_valid          <= 1'b0;
			jump_addr           <= 32'h0000_0000;
			sp_write            <= 1'b0;
			sp_value            <= 32'h0000_0000;
			mask_write          <= 1'b0;
			interrupt_mask_bits <= 4'h0;
			int_ack             <= 1'b0;
			int_ack_vector      <= 8'h00;
		end else begin
			// non-delayed jump: no slot instruction runs after the vector fetch
			jump_valid          <= vec_rd && vec_ack;
			sp_write            <= vec_rd && vec_ack;
			mask_write          <= vec_rd && vec_ack && is_int;
			int_ack             <= take_int && sel_int;
			if (vec_rd && vec_ack) begin
				jump_addr           <= vec_data;
				sp_value            <= sp_work;
				interrupt_mask_bits <= int_mask_new;
			end
			if (take_int && sel_int) begin
				int_ack_vector <= sel_vec;
			end
		end
	end

	chk_fetch_odd: assert property (@(posedge clk) disable iff (reset)
		fetch_valid && fetch_addr[0] |=> fetch_fault)
		else $error("odd fetch not flagged");
	chk_word_odd: assert property (@(posedge clk) disable iff (reset)
		data_valid && data_size == SIZE_WORD && data_addr[0] && !in_periph_d |=> data_fault)
		else $error("odd word access not flagged");
	chk_periph_ok: assert property (@(posedge clk) disable iff (reset)
		data_valid && in_periph_d |=> !data_fault)
		else $error("peripheral access flagged");
	chk_push_order: assert property (@(posedge clk) disable iff (reset)
		state == ST_PUSH_SR && stack_ack |=> state == ST_PUSH_PC && stack_data == saved_pc)
		else $error("program counter push out of order");
	chk_sp_step: assert property (@(posedge clk) disable iff (reset)
		state == ST_PUSH_PC |-> stack_addr == $past(stack_pointer, 1) - 32'h8
			|| $past(state) == ST_PUSH_PC)
		else $error("second push not at stack minus eight");
	chk_vec_addr: assert property (@(posedge clk) disable iff (reset)
		vec_rd |-> vec_addr == vector_base + 32'(vec_num) * 4)
		else $error("vector entry address wrong");
	chk_nmi_mask: assert property (@(posedge clk) disable iff (reset)
		mask_write && int_ack_vector == `VEC_NMI |-> interrupt_mask_bits == `MASK_AFTER_NMI)
		else $error("nmi mask not fifteen");
	chk_slot_hold: assert property (@(posedge clk) disable iff (reset)
		retire && (retire_dly_branch || retire_ctrl_ldst) |=> !int_ack)
		else $error("interrupt taken at held boundary");
	chk_mask_gate: assert property (@(posedge clk) disable iff (reset)
		int_ack && int_ack_vector != `VEC_NMI |-> $past(best_lvl) > $past(cur_mask))
		else $error("interrupt accepted at or below mask");

endmodule

// file: cpu_exception_sequencer_tb_top.sv
`timescale 1ns/10ps
`include "exc_seq_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: %h %h", $time, a, e); end end
module cpu_exception_sequencer_tb_top;
	import exc_seq_pkg::*;
	logic         clk, reset, single_chip_mode, fetch_valid, data_valid, retire, nmi_req;
	logic         retire_undefined, retire_pc_change, retire_dly_branch, retire_in_slot;
	logic         retire_trap, retire_ctrl_ldst, break_req, periph_req, jump_valid;
	logic         fetch_fault, data_fault, seq_busy, int_ack, stack_wr, stack_ack, vec_rd;
	logic         vec_ack, sp_write, mask_write, got_ack, jv;
	logic [31:0]  fetch_addr, data_addr, retire_addr, retire_next_addr, retire_branch_addr;
	logic [31:0]  retire_branch_target, status_word, stack_pointer, vector_base, vec_addr;
	logic [31:0]  priority_level_regs, stack_addr, stack_data, vec_data, jump_addr, sp_value;
	logic [31:0]  st_a[2], st_d[2], va, a, ra, rn, rb, rt;
	logic [15:0]  retire_code;
	logic [7:0]   retire_trap_vector, periph_vector, int_ack_vector, external_request_pins;
	logic [7:0]   ackv, tv, vc;
	logic [3:0]   periph_level, interrupt_mask_bits, lv;
	logic [1:0]   delay;
	access_size_t data_size;
	bus_master_t  data_master;
	int           bad_count, n_tests, ns;
	logic [31:0]  corner[8] = '{32'h1000, 32'h1001, `PERIPH_LO, 32'hffff_fffc, `EXT_LO,
		32'hfeff_fffc, 32'h00ff_fffc, 32'hff00_0000};

	cpu_exception_sequencer u_dut (
		.clk, .reset, .single_chip_mode, .fetch_valid, .fetch_addr, .data_valid, .data_size,
		.data_master, .data_addr, .retire, .retire_code, .retire_addr, .retire_next_addr,
		.retire_undefined, .retire_pc_change, .retire_dly_branch, .retire_in_slot,
		.retire_branch_addr, .retire_branch_target, .retire_trap, .retire_trap_vector,
		.retire_ctrl_ldst, .status_word, .stack_pointer, .vector_base, .nmi_req, .break_req,
		.external_request_pins, .priority_level_regs, .periph_req, .periph_level,
		.periph_vector, .fetch_fault, .data_fault, .seq_busy, .int_ack, .int_ack_vector,
		.stack_wr, .stack_addr, .stack_data, .stack_ack, .vec_rd, .vec_addr, .vec_ack,
		.vec_data, .jump_valid, .jump_addr, .sp_write, .sp_value, .mask_write,
		.interrupt_mask_bits);
	stack_vec_model u_mem (.clk, .reset, .delay, .stack_wr, .vec_rd, .vec_addr, .stack_ack,
		.vec_ack, .vec_data);

	function automatic logic ext_sp(logic [31:0] x);
		return single_chip_mode && x >= `EXT_LO && x <= `EXT_HI;
	endfunction
	function automatic logic exp_df(access_size_t s, logic [31:0] x);
		if (x >= `PERIPH_LO) return 1'b0;
		return (s == SIZE_WORD && x[0]) || (s == SIZE_LONG && x[1:0] != 2'h0) || ext_sp(x);
	endfunction

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic test_done;
		$display("mismatches %0d, compares %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		test_done();
	end

	task automatic setr(logic und, pcc, dly, slot, trp, ctl, logic [3:0] m);
		ra = $urandom & ~32'h1;
		rn = ra + 32'h2;
		rb = ra - 32'h2;
		rt = $urandom & ~32'h1;
		tv = 8'(32 + $urandom % 32);
		@(posedge clk);
		{retire_undefined, retire_pc_change, retire_dly_branch} <= {und, pcc, dly};
		{retire_in_slot, retire_trap, retire_ctrl_ldst} <= {slot, trp, ctl};
		retire_code <= und ? 16'hf000 | 16'($urandom % 4096) : 16'($urandom % 61440);
		retire_addr <= ra;
		retire_next_addr <= rn;
		retire_branch_addr <= rb;
		retire_branch_target <= rt;
		retire_trap_vector <= tv;
		status_word <= ($urandom & 32'hffff_ff0f) | {24'h0, m, 4'h0};
		stack_pointer <= $urandom & ~32'h3;
		vector_base <= $urandom & ~32'h3;
		delay <= 2'($urandom);
	endtask

	// one retire boundary, then follow the entry sequence to its jump
	task automatic fire(logic take, logic [7:0] vec, logic [31:0] pc, logic intr, logic [3:0] mk);
		retire <= 1'b1;
		@(posedge clk);
		{retire, fetch_valid, data_valid} <= 3'b000;
		{ns, got_ack, jv} = 0;
		for (int i = 0; i < 60; i++) begin
			@(negedge clk);
			if (i == 0 || !take) `CHK(seq_busy, take)
			if (!take && i == 3) break;
			if (int_ack) {got_ack, ackv} = {1'b1, int_ack_vector};
			if (stack_wr && stack_ack && ns < 2) {st_a[ns], st_d[ns], ns} = {stack_addr, stack_data, ns + 1};
			if (vec_rd && vec_ack) va = vec_addr;
			if (jump_valid) begin
				jv = 1'b1;
				`CHK(jump_addr, {va[15:0], ~va[15:0]})
				`CHK(sp_value, stack_pointer - 32'h8)
				`CHK(sp_write, 1'b1)
				`CHK(mask_write, intr)
				if (intr) `CHK(interrupt_mask_bits, mk)
				break;
			end
		end
		if (take) begin
			`CHK({jv, ns, got_ack}, {1'b1, 32'd2, intr})
			`CHK({st_a[0], st_d[0]}, {stack_pointer - 32'h4, status_word})
			`CHK({st_a[1], st_d[1]}, {stack_pointer - 32'h8, pc})
			`CHK(va, vector_base + {22'h0, vec, 2'b00})
			if (intr) `CHK(ackv, vec)
		end
	endtask

	initial begin
		void'($urandom(75));
		reset = 1'b1;
		{single_chip_mode, fetch_valid, data_valid, retire, nmi_req, break_req, periph_req} = '0;
		{fetch_addr, data_addr, status_word, stack_pointer, vector_base, delay} = '0;
		{retire_code, retire_addr, retire_next_addr, retire_branch_addr, retire_branch_target} = '0;
		{retire_undefined, retire_pc_change, retire_dly_branch, retire_in_slot} = '0;
		{retire_trap, retire_ctrl_ldst, retire_trap_vector, external_request_pins} = '0;
		{priority_level_regs, periph_level, periph_vector} = '0;
		data_size = SIZE_BYTE;
		data_master = MASTER_CPU;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 200; i++) begin
			a = (i < 24) ? corner[i / 3] : $urandom;
			@(posedge clk);
			{single_chip_mode, fetch_valid, data_valid, fetch_addr, data_addr} <= {i[1], 2'b11, a, a};
			data_size <= access_size_t'(i % 3);
			data_master <= bus_master_t'((i / 3) % 3);
			@(posedge clk);
			@(negedge clk);
			`CHK(fetch_fault, a[0] || a >= `PERIPH_LO || ext_sp(a))
			`CHK(data_fault, exp_df(data_size, a))
		end
		// sweep leaves address errors pending, so clear them by a second reset
		@(posedge clk);
		{reset, fetch_valid, data_valid, single_chip_mode} <= 4'b1000;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			setr(0, 0, 0, j[0], 0, 0, 4'h0);
			{fetch_valid, data_valid, fetch_addr, data_addr} <= {!j[1], j[1], 32'h2001, 32'h2002};
			data_size <= SIZE_LONG;
			data_master <= (j == 3) ? MASTER_XFER : MASTER_CPU;
			fire(1, (j == 3) ? `VEC_DMA_ADDR_ERR : `VEC_CPU_ADDR_ERR, j[0] ? rb : ra, 0, 0);
		end
		// cpu and dma faults on one boundary: cpu first, dma kept for the next
		setr(0, 0, 0, 0, 0, 0, 4'h0);
		{fetch_valid, data_valid} <= 2'b11;
		data_master <= MASTER_DMA;
		fire(1, `VEC_CPU_ADDR_ERR, ra, 0, 0);
		setr(0, 0, 0, 0, 0, 0, 4'h0);
		fire(1, `VEC_DMA_ADDR_ERR, ra, 0, 0);
		setr(1, 0, 0, 0, 0, 1, 4'h3);
		fire(1, `VEC_GEN_ILLEGAL, ra, 0, 0);
		setr(1, 0, 0, 1, 0, 0, 4'h3);
		fire(1, `VEC_SLOT_ILLEGAL, rt, 0, 0);
		setr(0, 1, 0, 1, 0, 0, 4'h3);
		fire(1, `VEC_SLOT_ILLEGAL, rt, 0, 0);
		setr(0, 0, 0, 0, 1, 1, 4'h3);
		fire(1, tv, rn, 0, 0);
		for (int k = 0; k < 11; k++) begin
			lv = (k == 1) ? `LVL_BREAK : 4'($urandom % 15 + 1);
			vc = (k == 0) ? `VEC_NMI : (k == 1) ? `VEC_BREAK : `VEC_EXT_BASE + 8'(k - 2);
			if (k == 10) vc = 8'(72 + $urandom % 184);
			for (int t = 0; t < 2; t++) begin
				setr(0, 0, 0, 0, 0, 0, (k == 0) ? 4'hf : lv - 4'(1 - t));
				{priority_level_regs, periph_level, periph_vector} <= {{8{lv}}, lv, vc};
				{nmi_req, break_req, periph_req} <= {k == 0, k == 1, k == 10};
				external_request_pins <= (k > 1 && k < 10) ? 8'(1 << (k - 2)) : 8'h0;
				fire(t == 0 || k == 0, vc, rn, 1, (k == 0) ? `MASK_AFTER_NMI : lv);
				@(posedge clk);
				{nmi_req, break_req, periph_req, external_request_pins} <= '0;
			end
		end
		// held across a delayed branch and a control load, then taken
		setr(0, 0, 1, 0, 0, 0, 4'h0);
		nmi_req <= 1'b1;
		fire(0, 0, 0, 0, 0);
		setr(0, 0, 0, 0, 0, 1, 4'h0);
		fire(0, 0, 0, 0, 0);
		setr(0, 0, 0, 0, 0, 0, 4'h0);
		fire(1, `VEC_NMI, rn, 1, `MASK_AFTER_NMI);
		test_done();
	end
endmodule

// file: exc_seq_cfg.svh
`ifndef EXC_SEQ_CFG_SVH
`define EXC_SEQ_CFG_SVH

// vector numbers of the fixed exception sources
`define VEC_GEN_ILLEGAL  8'h04
`define VEC_SLOT_ILLEGAL 8'h06
`define VEC_CPU_ADDR_ERR 8'h09
`define VEC_DMA_ADDR_ERR 8'h0a
`define VEC_NMI          8'h0b
`define VEC_BREAK        8'h0c
`define VEC_EXT_BASE     8'h40

// priority levels
`define LVL_NMI          5'h10
`define LVL_BREAK        4'hf
`define MASK_AFTER_NMI   4'hf

// interrupt mask field inside the status word
`define SR_MASK_LSB      4
`define SR_MASK_MSB      7

// address map: peripheral space and external space bounds
`define PERIPH_LO        32'hffff_0000
`define EXT_LO           32'h0100_0000
`define EXT_HI           32'hfeff_ffff

// stack step and vector entry scaling
`define STACK_STEP       32'h0000_0004
`define VEC_SHIFT        2

// undefined codes with guaranteed behaviour
`define UNDEF_TOP_NIBBLE 4'hf

`endif

// file: exc_seq_pkg.sv
package exc_seq_pkg;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'b00,
		SIZE_WORD = 2'b01,
		SIZE_LONG = 2'b10
	} access_size_t;

	typedef enum logic [1:0] {
		MASTER_CPU  = 2'b00,
		MASTER_DMA  = 2'b01,
		MASTER_XFER = 2'b10
	} bus_master_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PUSH_SR = 3'b001,
		ST_PUSH_PC = 3'b010,
		ST_VECTOR  = 3'b011,
		ST_JUMP    = 3'b100
	} seq_state_t;

endpackage

// file: stack_vec_model.sv
`timescale 1ns/10ps
module stack_vec_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// wait states per handshake
	input  wire logic [1:0]  delay,
	// stack and vector ports
	input  wire logic        stack_wr,
	input  wire logic        vec_rd,
	input  wire logic [31:0] vec_addr,
	output logic             stack_ack,
	output logic             vec_ack,
	output logic [31:0]      vec_data
);
	logic [1:0]  cnt;
	logic [31:0] noise;
	assign stack_ack = stack_wr & (cnt >= delay);
	assign vec_ack = vec_rd & (cnt >= delay);
	// outside an answer the data churns, so a stale sample cannot match
	assign vec_data = vec_ack ? {vec_addr[15:0], ~vec_addr[15:0]} : noise;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt <= 2'h0;
			noise <= 32'h0;
		end else begin
			noise <= noise + 32'h9e37_79b9;
			cnt <= (stack_ack | vec_ack | !(stack_wr | vec_rd)) ? 2'h0 : cnt + 2'h1;
		end
	end
endmodule
